// file: src/isel_top.sv
// Eight-way input selector with Avalon-MM register slave.
// Operation
// R1: Eight inputs with value and status; one exclude switch per input.
// R2: Input is invalid when excluded or bad; only valid inputs are candidates.
// R3: No valid input or fewer than minimum count: selected index is zero.
// R4: Below minimum count no selection happens, forced selection included.
// R5: Forced number one to eight copies that input and reports its number.
// R6: Forced pick passes value and status even of an invalid input.
// R7: Forced number zero lets the configured algorithm choose.
// R8: First good: lowest numbered valid input, re-evaluated continuously.
// R9: Minimum: valid input with smallest value and its number.
// R10: Maximum: valid input with largest value and its number.
// R11: Middle, odd count above one: middle ranked input and its number.
// R12: Middle, even count: mean of two middle values, index zero.
// R13: Average: mean of valid values, index is contributing count.
// R14: Latched good: hold lowest valid until invalid, then next by number.
// R15: Recovered lower input does not displace latch; search wraps eight to one.
// R16: Latched selection is kept where it survives power cycles; the code clears latch_q at reset, software may read and rewrite it.
// R17: Out of service accepts configuration but holds the output.
// R18: Manual keeps processing running while operator value drives output.
// R19: Automatic drives output from the selection continuously.
// R20: Output range setting is stored only, affects nothing.
// R21: Uncertain counts as bad unless the uncertain-as-good option is set.
// R22: Forced number above eight is invalid; index zero.
// R23: Ties in minimum, maximum or middle go to lowest input number.
// R24: Minimum count not met holds the previous output value.
`timescale 1ns/10ps
`include "isel_defines.svh"

module isel_top (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Candidate inputs, input n at bits n*width upward.
    input wire logic [`ISEL_NUM_IN*`ISEL_VAL_W-1:0] in_values,
    input wire logic [`ISEL_NUM_IN*`ISEL_STAT_W-1:0] in_status,
    // Avalon-MM register slave.
    input wire logic [`ISEL_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Selection results toward the controller.
    output logic [`ISEL_VAL_W-1:0] out_value,
    output logic [`ISEL_STAT_W-1:0] out_status,
    output logic [`ISEL_SEL_W-1:0] selected
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [1:0] mode_q;
    logic [2:0] sel_type_q;
    logic [`ISEL_SEL_W-1:0] forced_input_number_q;
    logic [`ISEL_SEL_W-1:0] min_good_q;
    logic [`ISEL_NUM_IN-1:0] excl_q;
    logic [0:0] status_handling_options_q;
    logic [31:0] out_range_q;
    isel_pkg::isel_val_t man_value_q;
    isel_pkg::isel_stat_t man_status_q;
    logic [`ISEL_SEL_W-1:0] latch_q;
    logic [`ISEL_SEL_W-1:0] latch_d;
    logic ack_q;
    logic bus_req;
    logic [31:0] rd_mux;
    logic [31:0] readdata_q;
    isel_pkg::isel_val_t out_value_q;
    isel_pkg::isel_val_t out_value_d;
    isel_pkg::isel_stat_t out_status_q;
    isel_pkg::isel_stat_t out_status_d;
    logic [`ISEL_SEL_W-1:0] sel_q;
    logic [`ISEL_SEL_W-1:0] sel_d;
    isel_pkg::isel_val_t in_val [`ISEL_NUM_IN];
    isel_pkg::isel_stat_t in_st [`ISEL_NUM_IN];
    logic [`ISEL_SEL_W-1:0] rank [`ISEL_NUM_IN];
    logic [`ISEL_NUM_IN-1:0] valid;
    logic [`ISEL_SEL_W-1:0] n_valid;
    logic enough;
    logic signed [`ISEL_SUM_W-1:0] sum;
    logic signed [`ISEL_SUM_W-1:0] avg;
    logic signed [`ISEL_PAIR_W-1:0] pair;
    logic [`ISEL_IDX_W-1:0] first_i;
    logic [`ISEL_IDX_W-1:0] min_i;
    logic [`ISEL_IDX_W-1:0] max_i;
    logic [`ISEL_IDX_W-1:0] mid_lo;
    logic [`ISEL_IDX_W-1:0] mid_hi;
    logic [`ISEL_IDX_W-1:0] force_i;
    logic [`ISEL_IDX_W-1:0] latch_i;
    logic [`ISEL_IDX_W-1:0] base_i;
    logic [`ISEL_IDX_W-1:0] search_i;
    logic search_hit;
    logic latch_ok;
    logic latch_run;

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Every access is answered on the second edge; waitrequest also holds while frozen.
    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !(ack_q && clk_en);
    assign avs_readdata = readdata_q;

    // The acknowledge toggles up for one edge after a request is first seen.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // Read data is captured one edge early so it stands at the answering edge.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `ISEL_REG_MODE: rd_mux[1:0] = mode_q;
            `ISEL_REG_TYPE: rd_mux[2:0] = sel_type_q;
            `ISEL_REG_FORCE: rd_mux[`ISEL_SEL_W-1:0] = forced_input_number_q;
            `ISEL_REG_MINGOOD: rd_mux[`ISEL_SEL_W-1:0] = min_good_q;
            `ISEL_REG_EXCL: rd_mux[`ISEL_NUM_IN-1:0] = excl_q;
            `ISEL_REG_OPTS: rd_mux[0:0] = status_handling_options_q;
            `ISEL_REG_RANGE: rd_mux = out_range_q;
            `ISEL_REG_MANVAL: rd_mux = {14'h0000, man_status_q, man_value_q};
            `ISEL_REG_OUT: rd_mux = {4'h0, sel_q, 6'h00, out_status_q, out_value_q};
            `ISEL_REG_LATCH: rd_mux[`ISEL_SEL_W-1:0] = latch_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata_q <= 32'h0000_0000;
        end else if (clk_en && avs_read && !ack_q) begin
            readdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // Writes land only at the answering edge; they are taken in every mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= `ISEL_MODE_OOS;
            sel_type_q <= `ISEL_TYPE_FIRST;
            forced_input_number_q <= '0;
            min_good_q <= `ISEL_RST_MINGOOD;
            excl_q <= '0;
            status_handling_options_q <= '0;
            out_range_q <= `ISEL_RST_RANGE;
            man_value_q <= '0;
            man_status_q <= `ISEL_ST_BAD;
        end else if (clk_en && avs_write && ack_q) begin // R17
            case (avs_address)
                `ISEL_REG_MODE: mode_q <= avs_writedata[1:0];
                `ISEL_REG_TYPE: sel_type_q <= avs_writedata[2:0];
                `ISEL_REG_FORCE: forced_input_number_q <= avs_writedata[`ISEL_SEL_W-1:0];
                `ISEL_REG_MINGOOD: min_good_q <= avs_writedata[`ISEL_SEL_W-1:0];
                `ISEL_REG_EXCL: excl_q <= avs_writedata[`ISEL_NUM_IN-1:0]; // R1
                `ISEL_REG_OPTS: status_handling_options_q <= avs_writedata[0:0];
                `ISEL_REG_RANGE: out_range_q <= avs_writedata; // R20
                `ISEL_REG_MANVAL: begin
                    man_value_q <= avs_writedata[`ISEL_VAL_W-1:0];
                    man_status_q <= avs_writedata[`ISEL_F_STAT_LSB +: `ISEL_STAT_W];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Per-input validity and rank
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `ISEL_NUM_IN; gi++) begin : g_in
            assign in_val[gi] = in_values[gi*`ISEL_VAL_W +: `ISEL_VAL_W];
            assign in_st[gi] = in_status[gi*`ISEL_STAT_W +: `ISEL_STAT_W];
            // Uncertain counts as good only with the option bit set.
            assign valid[gi] = !excl_q[gi] && ((in_st[gi] == `ISEL_ST_GOOD) || // R2
                ((in_st[gi] == `ISEL_ST_UNC) && status_handling_options_q[`ISEL_OPT_UNC_GOOD])); // R21
            // Rank counts smaller valid values; equal values rank by input number.
            always_comb begin
                rank[gi] = '0;
                for (int j = 0; j < `ISEL_NUM_IN; j++) begin
                    if (valid[j] && ((in_val[j] < in_val[gi]) || ((in_val[j] == in_val[gi]) && (j < gi)))) begin
                        rank[gi] = rank[gi] + 4'h1; // R23
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Candidates of every algorithm but latched good
    // ------------------------------------------------------------------------
    // Count, sum and the extreme inputs; strict compares keep the lowest number on ties.
    always_comb begin
        n_valid = '0;
        sum = '0;
        first_i = '0;
        min_i = '0;
        max_i = '0;
        mid_lo = '0;
        mid_hi = '0;
        for (int i = `ISEL_NUM_IN - 1; i >= 0; i--) begin
            if (valid[i]) begin
                first_i = 3'(i); // R8
            end
        end
        for (int i = 0; i < `ISEL_NUM_IN; i++) begin
            if (valid[i]) begin
                if ((n_valid == '0) || (in_val[i] < in_val[min_i])) begin
                    min_i = 3'(i); // R9 R23
                end
                if ((n_valid == '0) || (in_val[i] > in_val[max_i])) begin
                    max_i = 3'(i); // R10 R23
                end
                n_valid = n_valid + 4'h1;
                sum = sum + 19'(in_val[i]);
            end
        end
        for (int i = 0; i < `ISEL_NUM_IN; i++) begin
            if (valid[i] && (rank[i] == ((n_valid - 4'h1) >> 1))) begin
                mid_lo = 3'(i); // R11
            end
            if (valid[i] && (rank[i] == (n_valid >> 1))) begin
                mid_hi = 3'(i);
            end
        end
    end

    // Enough valid inputs gate every selection, forced or not.
    assign enough = (n_valid != '0) && (n_valid >= min_good_q); // R3 R4
    assign avg = sum / $signed({15'h0000, n_valid}); // R13
    assign pair = (17'(in_val[mid_lo]) + 17'(in_val[mid_hi])) >>> 1; // R12
    assign force_i = 3'(forced_input_number_q - 4'h1);

    // ------------------------------------------------------------------------
    // Latched good search
    // ------------------------------------------------------------------------
    // The search starts after the latched input and wraps from eight to one.
    assign latch_i = 3'(latch_q - 4'h1);
    assign latch_ok = (latch_q != '0) && valid[latch_i];
    assign base_i = (latch_q == '0) ? 3'(`ISEL_NUM_IN - 1) : latch_i;

    always_comb begin
        search_i = base_i;
        search_hit = 1'b0;
        for (int k = 1; k <= `ISEL_NUM_IN; k++) begin
            if (!search_hit && valid[3'(base_i + 3'(k))]) begin
                search_i = 3'(base_i + 3'(k)); // R15
                search_hit = 1'b1;
            end
        end
    end

    // Processing keeps the latch moving in manual as well as automatic.
    assign latch_run = (mode_q != `ISEL_MODE_OOS) && enough && (forced_input_number_q == '0) &&
        (sel_type_q == `ISEL_TYPE_LATCH);

    always_comb begin
        latch_d = latch_q;
        if (latch_run && !latch_ok) begin
            latch_d = {1'b0, search_i} + 4'h1; // R14
        end
    end

    // The latch is readable and writable so software can keep it in nonvolatile storage.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_q <= '0;
        end else if (clk_en) begin
            if (avs_write && ack_q && (avs_address == `ISEL_REG_LATCH)) begin
                latch_q <= avs_writedata[`ISEL_SEL_W-1:0]; // R16
            end else begin
                latch_q <= latch_d; // R15
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output decision
    // ------------------------------------------------------------------------
    // Holding is the default, so any unselected path keeps the previous value and status; the index defaults to zero.
    always_comb begin
        sel_d = '0;
        out_value_d = out_value_q;
        out_status_d = out_status_q;
        case (mode_q)
            `ISEL_MODE_MAN: begin
                out_value_d = man_value_q; // R18
                out_status_d = man_status_q;
            end
            `ISEL_MODE_AUTO: begin
                if (!enough) begin
                    sel_d = '0; // R3 R24
                end else if (forced_input_number_q > 4'(`ISEL_NUM_IN)) begin
                    out_value_d = '0; // R22
                    out_status_d = `ISEL_ST_BAD;
                end else if (forced_input_number_q != '0) begin
                    sel_d = forced_input_number_q; // R5
                    out_value_d = in_val[force_i]; // R6
                    out_status_d = in_st[force_i];
                end else begin
                    out_status_d = `ISEL_ST_GOOD; // R7 R19
                    case (sel_type_q)
                        `ISEL_TYPE_FIRST: begin
                            sel_d = {1'b0, first_i} + 4'h1; // R8
                            out_value_d = in_val[first_i];
                        end
                        `ISEL_TYPE_MIN: begin
                            sel_d = {1'b0, min_i} + 4'h1; // R9
                            out_value_d = in_val[min_i];
                        end
                        `ISEL_TYPE_MAX: begin
                            sel_d = {1'b0, max_i} + 4'h1; // R10
                            out_value_d = in_val[max_i];
                        end
                        `ISEL_TYPE_MID: begin
                            if (n_valid[0]) begin
                                sel_d = {1'b0, mid_lo} + 4'h1; // R11
                                out_value_d = in_val[mid_lo];
                            end else begin
                                out_value_d = pair[`ISEL_VAL_W-1:0]; // R12
                            end
                        end
                        `ISEL_TYPE_AVG: begin
                            sel_d = n_valid; // R13
                            out_value_d = avg[`ISEL_VAL_W-1:0];
                        end
                        `ISEL_TYPE_LATCH: begin
                            sel_d = latch_d; // R14
                            out_value_d = in_val[3'(latch_d - 4'h1)];
                        end
                        default: begin
                            out_status_d = out_status_q;
                        end
                    endcase
                end
            end
            default: begin
                sel_d = '0; // R17
            end
        endcase
    end

    // All selection outputs come from flip-flops; out of service and reset clear the index.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_q <= '0;
            out_value_q <= '0;
            out_status_q <= `ISEL_ST_BAD;
        end else if (clk_en) begin
            sel_q <= sel_d;
            out_value_q <= out_value_d;
            out_status_q <= out_status_d;
        end
    end

    assign selected = sel_q;
    assign out_value = out_value_q;
    assign out_status = out_status_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_all_excluded: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (clk_en && (excl_q == '1) && (mode_q == `ISEL_MODE_AUTO)) |=> (sel_q == '0))
        else $error("excluded inputs still selected");

    a_short_hold: assert property (@(posedge clk) disable iff (sys_rst) // R24
        (clk_en && !enough && (mode_q == `ISEL_MODE_AUTO)) |=> ((sel_q == '0) && $stable(out_value_q)))
        else $error("output changed below minimum count");

    a_short_noforce: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (clk_en && (n_valid < min_good_q) && (forced_input_number_q != '0)) |=> (sel_q == '0))
        else $error("forced pick made below minimum count");

    a_forced_pick: assert property (@(posedge clk) disable iff (sys_rst) // R6
        (clk_en && enough && (mode_q == `ISEL_MODE_AUTO) && (forced_input_number_q != '0) &&
        (forced_input_number_q <= 4'(`ISEL_NUM_IN))) |=>
        ((sel_q == $past(forced_input_number_q)) && (out_value_q == $past(in_val[force_i])) &&
        (out_status_q == $past(in_st[force_i]))))
        else $error("forced input not passed");

    a_forced_big: assert property (@(posedge clk) disable iff (sys_rst) // R22
        (clk_en && enough && (mode_q == `ISEL_MODE_AUTO) && (forced_input_number_q > 4'(`ISEL_NUM_IN)))
        |=> ((sel_q == '0) && (out_value_q == '0)))
        else $error("oversized forced number not refused");

    a_first_good: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (clk_en && enough && (mode_q == `ISEL_MODE_AUTO) && (forced_input_number_q == '0) &&
        (sel_type_q == `ISEL_TYPE_FIRST) && valid[0]) |=> (sel_q == 4'h1))
        else $error("first good skipped input one");

    a_mid_even: assert property (@(posedge clk) disable iff (sys_rst) // R12
        (clk_en && enough && (mode_q == `ISEL_MODE_AUTO) && (forced_input_number_q == '0) &&
        (sel_type_q == `ISEL_TYPE_MID) && !n_valid[0]) |=> (sel_q == '0))
        else $error("even middle reported an index");

    a_avg_count: assert property (@(posedge clk) disable iff (sys_rst) // R13
        (clk_en && enough && (mode_q == `ISEL_MODE_AUTO) && (forced_input_number_q == '0) &&
        (sel_type_q == `ISEL_TYPE_AVG)) |=> (sel_q == $past(n_valid)))
        else $error("average count wrong");

    a_latch_keep: assert property (@(posedge clk) disable iff (sys_rst) // R15
        (clk_en && latch_run && latch_ok && !(avs_write && ack_q)) |=> $stable(latch_q))
        else $error("latched input displaced while valid");

    a_oos_hold: assert property (@(posedge clk) disable iff (sys_rst) // R17
        (clk_en && (mode_q == `ISEL_MODE_OOS)) |=> ((sel_q == '0) && $stable(out_value_q)))
        else $error("output moved out of service");

    a_man_value: assert property (@(posedge clk) disable iff (sys_rst) // R18
        (clk_en && (mode_q == `ISEL_MODE_MAN)) |=> ((out_value_q == $past(man_value_q)) && (sel_q == '0)))
        else $error("manual value not driven");

endmodule : isel_top

// file: src/isel_defines.svh
// Constants of the eight-way input selector: widths, encodings, register map and reset values.
`ifndef ISEL_DEFINES_SVH
`define ISEL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Data path shape
// ----------------------------------------------------------------------------
`define ISEL_NUM_IN 8
`define ISEL_IDX_W 3
`define ISEL_SEL_W 4
`define ISEL_VAL_W 16
`define ISEL_STAT_W 2
`define ISEL_SUM_W 19
`define ISEL_PAIR_W 17

// ----------------------------------------------------------------------------
// Status codes and option bits
// ----------------------------------------------------------------------------
`define ISEL_ST_BAD 2'h0
`define ISEL_ST_UNC 2'h1
`define ISEL_ST_GOOD 2'h2
`define ISEL_OPT_UNC_GOOD 0

// ----------------------------------------------------------------------------
// Mode and algorithm codes
// ----------------------------------------------------------------------------
`define ISEL_MODE_OOS 2'h0
`define ISEL_MODE_MAN 2'h1
`define ISEL_MODE_AUTO 2'h2
`define ISEL_TYPE_FIRST 3'h1
`define ISEL_TYPE_MIN 3'h2
`define ISEL_TYPE_MAX 3'h3
`define ISEL_TYPE_MID 3'h4
`define ISEL_TYPE_AVG 3'h5
`define ISEL_TYPE_LATCH 3'h6

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ISEL_ADDR_W 6
`define ISEL_REG_MODE 6'h00
`define ISEL_REG_TYPE 6'h04
`define ISEL_REG_FORCE 6'h08
`define ISEL_REG_MINGOOD 6'h0c
`define ISEL_REG_EXCL 6'h10
`define ISEL_REG_OPTS 6'h14
`define ISEL_REG_RANGE 6'h18
`define ISEL_REG_MANVAL 6'h1c
`define ISEL_REG_OUT 6'h20
`define ISEL_REG_LATCH 6'h24

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ISEL_F_STAT_LSB 16
`define ISEL_F_SEL_LSB 24
`define ISEL_RST_MINGOOD 4'h1
`define ISEL_RST_RANGE 32'h0000_0000

`endif

// file: src/isel_pkg.sv
// Types shared by the eight-way input selector.
`include "isel_defines.svh"

package isel_pkg;

    // Operating modes of the block.
    typedef enum logic [1:0] {
        ISEL_OOS = `ISEL_MODE_OOS,
        ISEL_MAN = `ISEL_MODE_MAN,
        ISEL_AUTO = `ISEL_MODE_AUTO
    } isel_mode_t;

    // Value and status words of one input.
    typedef logic signed [`ISEL_VAL_W-1:0] isel_val_t;
    typedef logic [`ISEL_STAT_W-1:0] isel_stat_t;

endpackage : isel_pkg

// file: dv/isel_src_model.sv
// Upstream measurement sources feeding the eight candidate inputs.
`timescale 1ns/10ps
module isel_src_model (
    // Clock.
    input wire logic clk,
    // Load port for one source.
    input wire logic ld,
    input wire logic [2:0] idx,
    input wire logic [15:0] val,
    input wire logic [1:0] st,
    // Candidate inputs toward the selector.
    output logic [127:0] in_values,
    output logic [15:0] in_status
);
    // A source holds its last reading until reloaded, as a transmitter does.
    always_ff @(posedge clk) begin
        if (ld) begin
            in_values[idx*16 +: 16] <= val;
            in_status[idx*2 +: 2] <= st;
        end
    end
endmodule : isel_src_model

// file: dv/isel_tb.sv
// Self-checking bench of the eight-way input selector.
`timescale 1ns/10ps
module isel_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic we = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic ld = 1'b0;
    logic ce = 1'b1;
    logic [2:0] idx = 3'h0;
    logic [15:0] v = 16'h0000;
    logic [1:0] st = 2'h0;
    logic [31:0] rdata, got;
    logic wrq;
    logic [127:0] in_values;
    logic [15:0] in_status, out_value;
    logic [1:0] out_status;
    logic [3:0] selected;
    logic [31:0] tbl [6];
    logic [31:0] vv = 32'h5393_7182;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    isel_src_model u_isel_src_model (.clk(clk), .ld(ld), .idx(idx), .val(v), .st(st),
        .in_values(in_values), .in_status(in_status));
    isel_top u_isel_top (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .in_values(in_values),
        .in_status(in_status), .avs_address(adr), .avs_read(rd), .avs_write(we), .avs_writedata(wd),
        .avs_readdata(rdata), .avs_waitrequest(wrq), .out_value(out_value), .out_status(out_status),
        .selected(selected));
    // Clock of 5 ns.
    initial forever #2.5 clk = ~clk;
    // A hung handshake is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : ck
    // One bus access; the request stands until waitrequest is seen low.
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        we <= w;
        rd <= !w;
        @(posedge clk);
        while (wrq !== 1'b0) @(posedge clk);
        got = rdata;
        we <= 1'b0;
        rd <= 1'b0;
    endtask : acc
    task automatic setin(input logic [2:0] i, input logic [15:0] x, input logic [1:0] s);
        @(posedge clk);
        ld <= 1'b1;
        idx <= i;
        v <= x;
        st <= s;
        @(posedge clk);
        ld <= 1'b0;
    endtask : setin
    // Outputs have settled well after the one-cycle selection latency.
    task automatic look(input logic [3:0] es, input logic [15:0] ev);
        repeat (3) @(posedge clk);
        #1;
        ck("selected", 32'(es), 32'(selected));
        ck("out_value", 32'(ev), 32'(out_value));
    endtask : look
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Main sequence; table words are type, exclude mask, index and value.
    initial begin
        tbl = '{32'h1012_0003, 32'h2a02_0003, 32'h3047_0008, 32'h4f81_0005, 32'h4f00_0004, 32'h5f04_0005};
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) setin(i[2:0], 16'(vv[28-4*i +: 4]), 2'h2);
        acc(0, 6'h00, 0);
        ck("mode", 0, got);
        acc(0, 6'h0c, 0);
        ck("min_good", 1, got);
        acc(1, 6'h00, 2);
        for (int i = 0; i < 6; i++) begin
            acc(1, 6'h04, 32'(tbl[i][31:28]));
            acc(1, 6'h10, 32'(tbl[i][27:20]));
            look(tbl[i][19:16], tbl[i][15:0]);
        end
        // An algorithm code out of range holds the value and clears the index.
        acc(1, 6'h04, 7);
        look(4'h0, 16'h0005);
        acc(1, 6'h04, 5);
        setin(2, 16'h0009, 2'h0);
        acc(1, 6'h10, 4);
        acc(1, 6'h08, 3);
        look(4'h3, 16'h0009);
        ck("out_status", 0, 32'(out_status));
        acc(1, 6'h08, 9);
        look(4'h0, 16'h0000);
        acc(1, 6'h08, 0);
        acc(1, 6'h10, 32'h0000_00f0);
        look(4'h3, 16'h0003);
        acc(1, 6'h0c, 3);
        acc(1, 6'h10, 32'h0000_00fc);
        acc(1, 6'h08, 1);
        look(4'h0, 16'h0003);
        acc(1, 6'h08, 0);
        acc(1, 6'h0c, 1);
        setin(2, 16'h0009, 2'h1);
        acc(1, 6'h04, 1);
        acc(1, 6'h10, 3);
        look(4'h4, 16'h0003);
        acc(1, 6'h14, 1);
        look(4'h3, 16'h0009);
        // A low clock enable freezes the outputs although an input moves.
        @(posedge clk) ce <= 1'b0;
        setin(2, 16'h0006, 2'h2);
        look(4'h3, 16'h0009);
        @(posedge clk) ce <= 1'b1;
        look(4'h3, 16'h0006);
        acc(1, 6'h10, 0);
        acc(1, 6'h24, 0);
        acc(1, 6'h04, 6);
        look(4'h1, 16'h0005);
        acc(1, 6'h10, 1);
        look(4'h2, 16'h0003);
        acc(1, 6'h10, 0);
        look(4'h2, 16'h0003);
        acc(1, 6'h24, 8);
        acc(1, 6'h10, 32'h0000_0080);
        look(4'h1, 16'h0005);
        acc(1, 6'h10, 32'h0000_00ff);
        look(4'h0, 16'h0005);
        acc(0, 6'h24, 0);
        ck("latch", 1, got);
        acc(1, 6'h1c, 32'h0002_1234);
        acc(1, 6'h00, 1);
        look(4'h0, 16'h1234);
        acc(1, 6'h00, 0);
        setin(0, 16'h0077, 2'h2);
        look(4'h0, 16'h1234);
        acc(1, 6'h18, 32'hdead_beef);
        acc(0, 6'h18, 0);
        ck("range", 32'hdead_beef, got);
        acc(0, 6'h3c, 0);
        ck("unmapped", 0, got);
        end_of_test();
    end
endmodule : isel_tb
